// ---- src/fdd_pin_pkg.sv ----
// Constants shared by the floppy drive pin interface and its testbench
package fdd_pin_pkg;

	// ----------------------------------------
	// Clock
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 50; // 20 MHz core clock
	localparam int CNT_W = 8;

	// ----------------------------------------
	// Pin timing, in ns, then in cycles rounded up
	// ----------------------------------------
	localparam int STEP_SETUP_NS = 1000; // Direction stable before step
	localparam int STEP_PULSE_NS = 3000; // Low time of one step pulse
	localparam int STEP_RECOVER_NS = 3000; // High time after a step pulse
	localparam int GATE_LEAD_NS = 2000; // Write gate low before first flux edge
	localparam int FLUX_PULSE_NS = 250; // Low time of one write flux pulse
	localparam logic [CNT_W-1:0] STEP_SETUP_CYC = CNT_W'((STEP_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] STEP_PULSE_CYC = CNT_W'((STEP_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] STEP_RECOVER_CYC = CNT_W'((STEP_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] GATE_LEAD_CYC = CNT_W'((GATE_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] FLUX_PULSE_CYC = CNT_W'((FLUX_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// ----------------------------------------
	// Reset values and field positions
	// ----------------------------------------
	localparam logic PIN_INACTIVE = 1'b1; // Active-low pins idle high
	localparam logic DIR_RESET = 1'b1; // Outward
	localparam logic SIDE_RESET = 1'b1; // Side 0
	localparam int DIGIN_CHANGE_BIT = 7;

	// ----------------------------------------
	// Data rate codes, density modes and step and gate state encodings
	// ----------------------------------------
	typedef enum logic [1:0] {
		RATE_500K = 2'h0,
		RATE_300K = 2'h1,
		RATE_250K = 2'h2,
		RATE_1M = 2'h3
	} rate_t;

	typedef enum logic [1:0] {
		DEN_NORMAL = 2'h0,
		DEN_THREE_MODE = 2'h1,
		DEN_INVERTED = 2'h2,
		DEN_FIXED = 2'h3
	} den_mode_t;

	typedef enum logic [3:0] {
		STEP_IDLE = 4'h1,
		STEP_SETUP = 4'h2,
		STEP_PULSE = 4'h4,
		STEP_RECOVER = 4'h8
	} step_state_t;

	typedef enum logic [2:0] {
		GATE_OFF = 3'h1,
		GATE_LEAD = 3'h2,
		GATE_ON = 3'h4
	} gate_state_t;

endpackage

// ---- src/floppy_drive_pin_interface.sv ----
// Drive-side pin logic of the floppy controller: outputs to one drive, sensed inputs back
// Contract
// - Drive select pin low selects drive 0, high otherwise.
// - Motor pin low turns drive 0 motor on, high leaves it off.
// - Two density pins encode drive and media per configured density mode.
// - Direction pin 1 moves head outward, 0 moves it inward.
// - One low step pulse per single-track move, high between pulses.
// - Write flux pin gives one falling edge per recorded flux transition.
// - Write gate goes low before write data and only during a write.
// - Side select pin 1 accesses side 0, 0 accesses side 1.
// - Disk change input inverted and returned as bit 7 of digital input.
// - Force-change bits override the reported disk-change status bit.
`timescale 1ns/1ps
module floppy_drive_pin_interface (
	input wire logic mclk_i, // 20 MHz core clock
	input wire logic arst_n_i, // Async reset, active low
	input wire logic sel_req_i, // Controller selects drive 0
	input wire logic motor_req_i, // Controller wants motor on
	input wire fdd_pin_pkg::rate_t rate_i, // Current data rate
	input wire fdd_pin_pkg::den_mode_t den_mode_i, // Density pin mode setting
	input wire logic side1_req_i, // Access side 1 when high
	input wire logic step_valid_i, // Request one track step
	input wire logic step_inward_i, // Step direction, high inward
	output logic step_ready_o, // Step request accepted
	input wire logic write_req_i, // Write in progress, level
	output logic write_ready_o, // Gate lead met, flux may start
	input wire logic flux_valid_i, // One flux transition to record
	output logic flux_ready_o, // Flux request accepted
	input wire logic [1:0] force_change_i, // Force disk change bits
	output logic drive_select_n, // Drive select pin
	output logic motor_on_n, // Motor pin
	output logic density_out_0, // Density pin 0
	output logic density_out_1, // Density pin 1
	output logic head_direction, // Head direction pin
	output logic head_step_n, // Step pin
	output logic write_flux_n, // Write data pin
	output logic write_gate_n, // Write gate pin
	output logic side_select, // Side select pin
	input wire logic index_hole_n, // Index pin
	input wire logic track_zero_n, // Track zero pin
	input wire logic media_changed_n, // Disk change pin
	output logic index_o, // Head at index, level
	output logic index_edge_o, // Index start, one-cycle pulse
	output logic track_zero_o, // Head on outermost track
	output logic [7:0] digin_o // Digital input byte
);
	import fdd_pin_pkg::*;

	// ----------------------------------------
	// Density encoding
	// ----------------------------------------
	// Pins {density_out_1, density_out_0} for a rate in a mode
	function automatic logic [1:0] den_encode(input rate_t rate, input den_mode_t mode);
		logic [1:0] enc;
		enc = 2'h0;
		case (mode)
			DEN_NORMAL: enc = {1'b0, (rate == RATE_500K || rate == RATE_1M)};
			DEN_THREE_MODE: enc = {(rate == RATE_300K), (rate != RATE_250K)};
			DEN_INVERTED: enc = {1'b1, !(rate == RATE_500K || rate == RATE_1M)};
			DEN_FIXED: enc = 2'h0;
			default: enc = 2'h0;
		endcase
		return enc;
	endfunction

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	logic index_lvl;
	logic trk0_lvl;
	logic chg_lvl;
	logic index_prev;
	logic next_index_prev;

	pin_sync3 #(.RESET_VAL(PIN_INACTIVE)) u_sync_index (
		.mclk_i(mclk_i),
		.arst_n_i(arst_n_i),
		.pin_i(index_hole_n),
		.level_o(index_lvl)
	);

	pin_sync3 #(.RESET_VAL(PIN_INACTIVE)) u_sync_trk0 (
		.mclk_i(mclk_i),
		.arst_n_i(arst_n_i),
		.pin_i(track_zero_n),
		.level_o(trk0_lvl)
	);

	pin_sync3 #(.RESET_VAL(PIN_INACTIVE)) u_sync_chg (
		.mclk_i(mclk_i),
		.arst_n_i(arst_n_i),
		.pin_i(media_changed_n),
		.level_o(chg_lvl)
	);

	// ----------------------------------------
	// Static drive outputs and sensed status
	// ----------------------------------------
	logic next_sel_n;
	logic next_motor_n;
	logic [1:0] next_den;
	logic next_side;
	logic next_index_o;
	logic next_index_edge;
	logic next_trk0_o;
	logic [7:0] next_digin;

	// Pins follow controller requests; status decoded from filtered inputs
	always_comb begin
		next_sel_n = !sel_req_i;
		next_motor_n = !motor_req_i;
		next_den = den_encode(rate_i, den_mode_i);
		next_side = !side1_req_i;
		next_index_prev = index_lvl;
		next_index_o = !index_lvl;
		next_index_edge = index_prev && !index_lvl;
		next_trk0_o = !trk0_lvl;
		next_digin = 8'h00;
		next_digin[DIGIN_CHANGE_BIT] = !chg_lvl || (|force_change_i);
	end

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			drive_select_n <= PIN_INACTIVE;
			motor_on_n <= PIN_INACTIVE;
			{density_out_1, density_out_0} <= 2'h0;
			side_select <= SIDE_RESET;
			index_prev <= PIN_INACTIVE;
			index_o <= 1'b0;
			index_edge_o <= 1'b0;
			track_zero_o <= 1'b0;
			digin_o <= 8'h00;
		end else begin
			drive_select_n <= next_sel_n;
			motor_on_n <= next_motor_n;
			{density_out_1, density_out_0} <= next_den;
			side_select <= next_side;
			index_prev <= next_index_prev;
			index_o <= next_index_o;
			index_edge_o <= next_index_edge;
			track_zero_o <= next_trk0_o;
			digin_o <= next_digin;
		end
	end

	// ----------------------------------------
	// Step sequencer
	// ----------------------------------------
	step_state_t step_state;
	step_state_t next_step_state;
	logic [CNT_W-1:0] step_cnt;
	logic [CNT_W-1:0] next_step_cnt;
	logic next_dir;
	logic next_step_n;

	// Direction settles before the pulse, so the drive never sees a step on a moving level
	assign step_ready_o = (step_state == STEP_IDLE);

	always_comb begin
		next_step_state = step_state;
		next_step_cnt = step_cnt;
		next_dir = head_direction;
		next_step_n = PIN_INACTIVE;
		case (step_state)
			STEP_IDLE: begin
				if (step_valid_i) begin
					next_dir = !step_inward_i;
					next_step_cnt = STEP_SETUP_CYC - 8'h01;
					next_step_state = STEP_SETUP;
				end
			end
			STEP_SETUP: begin
				if (step_cnt == 8'h00) begin
					next_step_n = 1'b0;
					next_step_cnt = STEP_PULSE_CYC - 8'h01;
					next_step_state = STEP_PULSE;
				end else begin
					next_step_cnt = step_cnt - 8'h01;
				end
			end
			STEP_PULSE: begin
				if (step_cnt == 8'h00) begin
					next_step_cnt = STEP_RECOVER_CYC - 8'h01;
					next_step_state = STEP_RECOVER;
				end else begin
					next_step_n = 1'b0;
					next_step_cnt = step_cnt - 8'h01;
				end
			end
			STEP_RECOVER: begin
				if (step_cnt == 8'h00) begin
					next_step_state = STEP_IDLE;
				end else begin
					next_step_cnt = step_cnt - 8'h01;
				end
			end
			default: begin
				next_step_state = STEP_IDLE;
				next_step_cnt = 8'h00;
			end
		endcase
	end

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			step_state <= STEP_IDLE;
			step_cnt <= 8'h00;
			head_direction <= DIR_RESET;
			head_step_n <= PIN_INACTIVE;
		end else begin
			step_state <= next_step_state;
			step_cnt <= next_step_cnt;
			head_direction <= next_dir;
			head_step_n <= next_step_n;
		end
	end

	// ----------------------------------------
	// Write gate and flux pulses
	// ----------------------------------------
	gate_state_t gate_state;
	gate_state_t next_gate_state;
	logic [CNT_W-1:0] gate_cnt;
	logic [CNT_W-1:0] next_gate_cnt;
	logic [CNT_W-1:0] flux_cnt;
	logic [CNT_W-1:0] next_flux_cnt;
	logic next_gate_n;
	logic next_flux_n;

	// Flux taken only with the lead met, the write still asked for and no pulse in flight,
	// so a pulse can never start on the edge at which the gate is released
	assign write_ready_o = (gate_state == GATE_ON);
	assign flux_ready_o = write_ready_o && write_req_i && (flux_cnt == 8'h00);

	always_comb begin
		next_gate_state = gate_state;
		next_gate_cnt = gate_cnt;
		next_gate_n = PIN_INACTIVE;
		case (gate_state)
			GATE_OFF: begin
				if (write_req_i) begin
					next_gate_n = 1'b0;
					next_gate_cnt = GATE_LEAD_CYC - 8'h01;
					next_gate_state = GATE_LEAD;
				end
			end
			GATE_LEAD: begin
				next_gate_n = !write_req_i;
				if (!write_req_i) begin
					next_gate_state = GATE_OFF;
				end else if (gate_cnt == 8'h00) begin
					next_gate_state = GATE_ON;
				end else begin
					next_gate_cnt = gate_cnt - 8'h01;
				end
			end
			GATE_ON: begin
				// Gate held until the last flux pulse has finished
				next_gate_n = !(write_req_i || flux_cnt != 8'h00);
				if (next_gate_n) begin
					next_gate_state = GATE_OFF;
				end
			end
			default: begin
				next_gate_state = GATE_OFF;
				next_gate_cnt = 8'h00;
			end
		endcase
	end

	// Each accepted flux request gives one falling edge and a fixed low time
	always_comb begin
		next_flux_cnt = flux_cnt;
		next_flux_n = PIN_INACTIVE;
		if (flux_cnt != 8'h00) begin
			next_flux_cnt = flux_cnt - 8'h01;
			next_flux_n = (flux_cnt == 8'h01);
		end else if (flux_valid_i && flux_ready_o) begin
			next_flux_cnt = FLUX_PULSE_CYC;
			next_flux_n = 1'b0;
		end
	end

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			gate_state <= GATE_OFF;
			gate_cnt <= 8'h00;
			flux_cnt <= 8'h00;
			write_gate_n <= PIN_INACTIVE;
			write_flux_n <= PIN_INACTIVE;
		end else begin
			gate_state <= next_gate_state;
			gate_cnt <= next_gate_cnt;
			flux_cnt <= next_flux_cnt;
			write_gate_n <= next_gate_n;
			write_flux_n <= next_flux_n;
		end
	end
endmodule

// ---- src/pin_sync3.sv ----
// Three-stage input synchroniser with second/third stage agreement
`timescale 1ns/1ps
module pin_sync3 #(
	parameter logic RESET_VAL = 1'b1
) (
	input wire logic mclk_i, // Core clock
	input wire logic arst_n_i, // Async reset, active low
	input wire logic pin_i, // Raw pin
	output logic level_o // Filtered level
);
	logic s1;
	logic s2;
	logic s3;
	logic next_level;

	// ----------------------------------------
	// Accept a change only when stages two and three agree
	// ----------------------------------------
	always_comb begin
		next_level = level_o;
		if (s2 == s3) begin
			next_level = s3;
		end
	end

	// Stage one feeds stage two only, to keep metastability contained
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			s1 <= RESET_VAL;
			s2 <= RESET_VAL;
			s3 <= RESET_VAL;
			level_o <= RESET_VAL;
		end else begin
			s1 <= pin_i;
			s2 <= s1;
			s3 <= s2;
			level_o <= next_level;
		end
	end
endmodule

// ---- verification/fdd_drive_model.sv ----
// Behavioural single floppy drive: head position, spindle index, door
`timescale 1ns/1ps
module fdd_drive_model (
	input wire logic mclk_i, // Core clock
	input wire logic motor_on_n, // Spindle on, low
	input wire logic head_direction, // 1 outward
	input wire logic head_step_n, // Step pulse
	input wire logic door_open_i, // Door state from bench
	output logic index_hole_n, // Index pin
	output logic track_zero_n, // Track zero pin
	output logic media_changed_n // Disk change pin
);
	int track = 2;
	int rot = 10;
	int revs = 0;
	// Head moves on the falling step edge; the outer stop holds it at 0
	always @(negedge head_step_n) begin
		track = head_direction ? (track > 0 ? track - 1 : 0) : track + 1;
	end
	// Spindle turns only with the motor on; hole spans 10 of 400 cycles
	always @(posedge mclk_i) begin
		if (!motor_on_n) begin
			rot <= (rot + 1) % 400;
			revs <= revs + (rot == 399);
		end
	end
	assign index_hole_n = !(rot < 10);
	assign track_zero_n = (track != 0);
	assign media_changed_n = !door_open_i;
endmodule

// ---- verification/floppy_drive_pin_interface_properties.sv ----
// Concurrent checks on the floppy drive pin interface ports
`timescale 1ns/1ps
module floppy_pin_checker (
	input wire logic mclk_i,
	input wire logic arst_n_i,
	input wire logic sel_req_i,
	input wire logic side1_req_i,
	input wire logic step_valid_i,
	input wire logic step_inward_i,
	input wire logic step_ready_o,
	input wire logic write_ready_o,
	input wire logic [1:0] force_change_i,
	input wire logic drive_select_n,
	input wire logic side_select,
	input wire logic head_direction,
	input wire logic head_step_n,
	input wire logic write_flux_n,
	input wire logic write_gate_n,
	input wire logic index_o,
	input wire logic index_edge_o,
	input wire logic [7:0] digin_o
);
	// ----------------------------------------
	// Pin relations, one clock domain
	// ----------------------------------------
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!arst_n_i);

	a_select_follows: assert property (drive_select_n == !$past(sel_req_i))
		else $error("select pin does not follow request");
	a_side_follows: assert property (side_select == !$past(side1_req_i))
		else $error("side pin does not follow request");
	a_step_take: assert property (step_valid_i && step_ready_o |=>
		(head_direction == !$past(step_inward_i)) ##20 $fell(head_step_n))
		else $error("step direction or pulse start wrong");
	a_step_len: assert property ($fell(head_step_n) |-> ##59 !head_step_n ##1 head_step_n)
		else $error("step pulse length wrong");
	a_gate_lead: assert property ($fell(write_gate_n) |-> ##40 write_ready_o)
		else $error("write gate lead time wrong");
	a_flux_gated: assert property ($fell(write_flux_n) |-> !write_gate_n && $past(write_ready_o))
		else $error("flux edge outside write gate");
	a_gate_idle: assert property (write_gate_n |-> write_flux_n)
		else $error("flux low with gate off");
	a_force_change: assert property (|force_change_i |=> digin_o[7])
		else $error("force bit not reported");
	a_index_edge: assert property (index_edge_o |-> index_o && !$past(index_o))
		else $error("index edge without new index");
	a_reset_idle: assert property ($rose(arst_n_i) |-> head_step_n && write_flux_n && write_gate_n)
		else $error("drive pins active after reset");
endmodule

bind floppy_drive_pin_interface floppy_pin_checker i_floppy_pin_checker (.*);

// ---- verification/tb_top.sv ----
// Self-checking bench for the floppy drive pin interface
`timescale 1ns/1ps
module tb_top;
	import fdd_pin_pkg::*;
	logic mclk_i = 0, arst_n_i = 0, sel_req_i = 0, motor_req_i = 0, side1_req_i = 0;
	logic step_valid_i = 0, step_inward_i = 0, write_req_i = 0, flux_valid_i = 0, door_open_i = 0;
	rate_t rate_i = RATE_500K;
	den_mode_t den_mode_i = DEN_NORMAL;
	logic [1:0] force_change_i = 2'h0;
	logic step_ready_o, write_ready_o, flux_ready_o, drive_select_n, motor_on_n, density_out_0;
	logic density_out_1, head_direction, head_step_n, write_flux_n, write_gate_n, side_select;
	logic index_hole_n, track_zero_n, media_changed_n, index_o, index_edge_o, track_zero_o;
	logic [7:0] digin_o;
	int err_count = 0, check_count = 0, seed = 74846, falls = 0, fl = 0, bad = 0, edges = 0, i, n;

	floppy_drive_pin_interface i_floppy_drive_pin_interface (.*);
	fdd_drive_model i_fdd_drive_model (.*);
	always #25 mclk_i = ~mclk_i;

	// ----------------------------------------
	// Edge monitors, tallied against requests
	// ----------------------------------------
	always @(negedge head_step_n) falls++;
	always @(negedge write_flux_n) begin
		fl++;
		bad += write_gate_n;
	end
	always @(posedge mclk_i) edges += index_edge_o;

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic tick(int k);
		repeat (k) @(posedge mclk_i);
		#2;
	endtask
	// Handshake flag picked by number, so no reference argument is needed
	function automatic logic flag(int sel);
		case (sel)
			0: return step_ready_o;
			1: return write_ready_o;
			default: return flux_ready_o;
		endcase
	endfunction
	// Bounded wait on a flag; the flag seen here is what the next edge samples
	task automatic wait_hi(input int sel, input int lim);
		for (n = 0; flag(sel) !== 1'b1 && n < lim; n++) tick(1);
		if (flag(sel) !== 1'b1) begin
			err_count++;
			$display("ERROR wait %0d expected 1 seen %b", sel, flag(sel));
			tally_and_finish;
		end
	endtask
	function automatic logic [1:0] den_exp(int m, int r);
		case (m)
			0: return {1'b0, r == 0 || r == 3};
			1: return {r == 1, r != 2};
			2: return {1'b1, !(r == 0 || r == 3)};
			default: return 2'h0;
		endcase
	endfunction

	initial begin
		repeat (6) @(posedge mclk_i);
		#2 arst_n_i = 1;
		tick(1);
		chk("idle", {drive_select_n, motor_on_n, head_step_n, write_flux_n, write_gate_n, head_direction, side_select}, 8'h7f);
		$display("reset test done");
		// Every density mode against every rate, random select, motor and side
		for (i = 0; i < 16; i++) begin
			{sel_req_i, motor_req_i, side1_req_i} = 3'($random(seed));
			den_mode_i = den_mode_t'(i / 4);
			rate_i = rate_t'(i % 4);
			tick(2);
			chk("select", drive_select_n, !sel_req_i);
			chk("motor", motor_on_n, !motor_req_i);
			chk("side", side_select, !side1_req_i);
			chk("density", {density_out_1, density_out_0}, den_exp(i / 4, i % 4));
		end
		motor_req_i = 1;
		$display("static test done");
		// Back-to-back steps: two outward reach track 0, one inward leaves it
		for (i = 0; i < 3; i++) begin
			step_inward_i = (i == 2);
			step_valid_i = 1;
			wait_hi(0, 10);
			tick(1);
			step_valid_i = 0;
			tick(1);
			chk("direction", head_direction, !step_inward_i);
			wait_hi(0, 200);
			chk("steps", 8'(falls), 8'(i + 1));
			chk("track0", track_zero_o, i == 1);
		end
		$display("step test done");
		// Gate leads the data; each flux request is one edge inside the gate
		write_req_i = 1;
		wait_hi(1, 60);
		chk("gate", write_gate_n, 1'h0);
		for (i = 0; i < 4; i++) begin
			flux_valid_i = 1;
			wait_hi(2, 10);
			tick(1);
			flux_valid_i = 0;
			tick(1);
		end
		tick(8);
		chk("flux", 8'(fl), 8'h4);
		chk("outside", 8'(bad), 8'h0);
		write_req_i = 0;
		tick(2);
		chk("gate off", write_gate_n, 1'h1);
		$display("write test done");
		// Spindle turns a few times; each hole pass reported once
		tick(1300);
		motor_req_i = 0;
		tick(20);
		chk("index", 8'(edges), 8'(i_fdd_drive_model.revs));
		chk("index level", index_o, !index_hole_n);
		$display("index test done");
		// Door and force bits against the change flag
		for (i = 0; i < 8; i++) begin
			{door_open_i, force_change_i} = 3'(i);
			tick(6);
			chk("digin", digin_o, {door_open_i || force_change_i != 2'h0, 7'h0});
		end
		$display("change test done");
		tally_and_finish;
	end
endmodule
